// ==== tsq_responder.sv ====
// Purpose: parses query packets and answers with framed responses
// Assumes: receive bytes come from logic on the same clock
// Notes:   registers over classic Wishbone, 32-bit aligned words
//
// Behaviour
// - length field in bytes 3-4 counts mode, data and checksum bytes.
// - frames open with 10, identifier A1, and close with 10 03.
// - timing answer: mode 2, week time, week, clock, date, year.
// - byte 19 time base: constellation in bits 2:0, UTC in bit 3.
// - byte 20 pulse base uses the same encoding as time base.
// - byte 21 holds UTC and time valid flags; bytes 22-23 UTC offset.
// - frequency answer: DAC voltage, DAC code, holdover, temperature.
// - multi-byte fields go most significant byte first.
// - a bad checksum gets a checksum error message back.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tsq_responder
  import tsq_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic [7:0]  RX_DATA_IN,
  input  wire logic        RX_VALID_IN,
  output logic             RX_READY_OUT,
  output logic      [7:0]  TX_DATA_OUT,
  output logic             TX_VALID_OUT,
  input  wire logic        TX_READY_IN
);
  typedef enum logic [3:0] {
    P_HUNT, P_ID, P_SUB, P_LENH, P_LENL, P_MODE, P_BODY, P_CKS, P_END1,
    P_END2
  } tsq_pst_e;

  tsq_pst_e    pst_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] data_reg [2:TSQ_NWORDS-1];
  logic [7:0]  sub_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  lenh_reg;
  logic [15:0] rem_reg;
  logic [7:0]  xor_reg;
  logic        ck_ok_reg;
  logic        first_reg;
  logic [3:0]  mask_tmp_reg;
  logic [3:0]  mask_reg;
  logic [7:0]  ok_cnt_reg;
  logic [7:0]  err_cnt_reg;
  logic        pend_reg;
  logic        pend_next;
  tsq_hdr_s    hdr_reg;
  logic [5:0]  nd_reg;
  logic        take;
  logic        done;
  logic        req;
  logic        start;
  logic        busy;
  logic [239:0] payload;
  logic [3:0]  widx;
  logic [31:0] status_w;

  ////////////////////////////////////////////////////////////////////////
  // register bus

  // merge write data under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  assign widx     = WB_ADR_IN[5:2];
  assign status_w = {11'h000, busy, mask_reg, err_cnt_reg, ok_cnt_reg};

  // one wait state: ack follows stb by one edge, then drops
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    end
  end

  // read data; unmapped words read zero
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      WB_DAT_OUT <= 32'h0000_0000;
    end else if (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) begin
      if (WB_ADR_IN == TSQ_R_CTRL)        WB_DAT_OUT <= ctrl_reg;
      else if (WB_ADR_IN == TSQ_R_STATUS) WB_DAT_OUT <= status_w;
      else if (WB_ADR_IN[1:0] == 2'b00 && WB_ADR_IN <= TSQ_R_TEMP)
        WB_DAT_OUT <= data_reg[widx];
      else                                WB_DAT_OUT <= 32'h0000_0000;
    end
  end

  // writes take effect on the acknowledging edge
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ctrl_reg <= TSQ_CTRL_RST;
      for (int i = 2; i < TSQ_NWORDS; i++) data_reg[i] <= 32'h0000_0000;
    end else if (WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT) begin
      if (WB_ADR_IN == TSQ_R_CTRL)
        ctrl_reg <= merge(ctrl_reg, WB_DAT_IN, WB_SEL_IN);
      else if (WB_ADR_IN[1:0] == 2'b00 && WB_ADR_IN >= TSQ_R_TOW &&
               WB_ADR_IN <= TSQ_R_TEMP)
        data_reg[widx] <= merge(data_reg[widx], WB_DAT_IN, WB_SEL_IN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // query parser

  // bytes are only taken while no answer waits for the framer
  assign take = RX_VALID_IN && RX_READY_OUT && ctrl_reg[TSQ_CTRL_EN];
  assign done = take && pst_reg == P_END2 && RX_DATA_IN == TSQ_END2;

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      pst_reg      <= P_HUNT;
      sub_reg      <= 8'h00;
      mode_reg     <= 8'h00;
      lenh_reg     <= 8'h00;
      rem_reg      <= 16'h0000;
      xor_reg      <= 8'h00;
      ck_ok_reg    <= 1'b0;
      first_reg    <= 1'b0;
      mask_tmp_reg <= 4'h0;
    end else if (take) begin
      unique case (pst_reg)
        P_HUNT: if (RX_DATA_IN == TSQ_START) pst_reg <= P_ID;
        P_ID: begin
          xor_reg <= RX_DATA_IN;
          pst_reg <= (RX_DATA_IN == TSQ_PKT_ID) ? P_SUB : P_HUNT;
        end
        P_SUB: begin
          sub_reg <= RX_DATA_IN;
          xor_reg <= xor_reg ^ RX_DATA_IN;
          pst_reg <= P_LENH;
        end
        P_LENH: begin
          lenh_reg <= RX_DATA_IN;
          xor_reg  <= xor_reg ^ RX_DATA_IN;
          pst_reg  <= P_LENL;
        end
        P_LENL: begin
          // too short to hold mode and checksum, or too long: resync
          xor_reg <= xor_reg ^ RX_DATA_IN;
          rem_reg <= {lenh_reg, RX_DATA_IN} - 16'h0002;
          if ({lenh_reg, RX_DATA_IN} < 16'h0002 ||
              {lenh_reg, RX_DATA_IN} > TSQ_MAX_LEN) pst_reg <= P_HUNT;
          else                                    pst_reg <= P_MODE;
        end
        P_MODE: begin
          mode_reg  <= RX_DATA_IN;
          xor_reg   <= xor_reg ^ RX_DATA_IN;
          first_reg <= 1'b1;
          pst_reg   <= (rem_reg == 16'h0000) ? P_CKS : P_BODY;
        end
        P_BODY: begin
          xor_reg   <= xor_reg ^ RX_DATA_IN;
          first_reg <= 1'b0;
          if (first_reg && sub_reg == TSQ_SUB_POS)
            mask_tmp_reg <= RX_DATA_IN[3:0];
          rem_reg <= rem_reg - 16'h0001;
          if (rem_reg == 16'h0001) pst_reg <= P_CKS;
        end
        P_CKS: begin
          ck_ok_reg <= (RX_DATA_IN == xor_reg);
          pst_reg   <= P_END1;
        end
        P_END1: pst_reg <= (RX_DATA_IN == TSQ_END1) ? P_END2 : P_HUNT;
        P_END2: pst_reg <= P_HUNT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dispatch

  // a bad checksum always earns an error answer; good queries by kind
  assign req = done && (!ck_ok_reg || (mode_reg == TSQ_MODE_QRY &&
               (sub_reg == TSQ_SUB_TIME || sub_reg == TSQ_SUB_FREQ)));
  assign start     = pend_reg && !busy;
  assign pend_next = (pend_reg && !start) || req;

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      pend_reg     <= 1'b0;
      RX_READY_OUT <= 1'b0;
    end else begin
      pend_reg     <= pend_next;
      RX_READY_OUT <= !pend_next;
    end
  end

  // header and size of the pending answer
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      hdr_reg <= '0;
      nd_reg  <= TSQ_ND_ERR;
    end else if (req) begin
      hdr_reg.id   <= TSQ_PKT_ID;
      hdr_reg.mode <= TSQ_MODE_RSP;
      if (!ck_ok_reg) begin
        hdr_reg.sub <= TSQ_SUB_ERR;
        nd_reg      <= TSQ_ND_ERR;
      end else begin
        hdr_reg.sub <= sub_reg;
        nd_reg <= (sub_reg == TSQ_SUB_TIME) ? TSQ_ND_TIME : TSQ_ND_FREQ;
      end
    end
  end

  // position mask kept for software; position queries get no answer
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      mask_reg    <= 4'h0;
      ok_cnt_reg  <= 8'h00;
      err_cnt_reg <= 8'h00;
    end else if (done) begin
      if (!ck_ok_reg) err_cnt_reg <= err_cnt_reg + 8'h01;
      else            ok_cnt_reg  <= ok_cnt_reg + 8'h01;
      if (ck_ok_reg && mode_reg == TSQ_MODE_QRY && sub_reg == TSQ_SUB_POS)
        mask_reg <= mask_tmp_reg;
    end
  end

  // payloads, most significant byte first, reserved bits zero
  always_comb begin
    if (hdr_reg.sub == TSQ_SUB_TIME) begin
      payload = {data_reg[2], data_reg[3][31:16], data_reg[4],
                 data_reg[5][31:24], data_reg[3][15:0],
                 4'h0, data_reg[5][19:16],
                 4'h0, data_reg[5][11:8],
                 6'h00, data_reg[5][1:0], data_reg[6][15:0],
                 data_reg[7], data_reg[8], data_reg[9]};
    end else begin
      payload = {data_reg[10], data_reg[11][31:16],
                 data_reg[11][7:0], data_reg[12], data_reg[13],
                 120'h0};
    end
  end

  tsq_framer #(
    .MAXD       (TSQ_MAXD)
  ) u_framer (
    .clk_in     (CLOCK_IN),
    .rst_n_in   (RST_N_IN),
    .start_in   (start),
    .hdr_in     (hdr_reg),
    .ndata_in   (nd_reg),
    .payload_in (payload),
    .tx_data_out  (TX_DATA_OUT),
    .tx_valid_out (TX_VALID_OUT),
    .tx_ready_in  (TX_READY_IN),
    .busy_out     (busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_ack;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing");
  property p_err;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      done && !ck_ok_reg |=> pend_reg && hdr_reg.sub == TSQ_SUB_ERR;
  endproperty
  a_err: assert property (p_err) else $error("no checksum error");
  property p_echo;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      req && ck_ok_reg |=> hdr_reg.sub == $past(sub_reg) &&
      hdr_reg.id == TSQ_PKT_ID && hdr_reg.mode == TSQ_MODE_RSP;
  endproperty
  a_echo: assert property (p_echo) else $error("header not echoed");
  property p_mask;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      done && ck_ok_reg && mode_reg == TSQ_MODE_QRY &&
      sub_reg == TSQ_SUB_POS |=> mask_reg == $past(mask_tmp_reg);
  endproperty
  a_mask: assert property (p_mask) else $error("mask lost");
  property p_len;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      take && pst_reg == P_LENL && {lenh_reg, RX_DATA_IN} == 16'h0002
      |=> pst_reg == P_MODE ##0 rem_reg == 16'h0000;
  endproperty
  a_len: assert property (p_len) else $error("length count");
  property p_tbase;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      hdr_reg.sub == TSQ_SUB_TIME |-> payload[135:132] == 4'h0 &&
      payload[131:128] == data_reg[5][19:16] &&
      payload[127:124] == 4'h0 &&
      payload[123:120] == data_reg[5][11:8];
  endproperty
  a_tbase: assert property (p_tbase) else $error("base bytes");
  property p_flags;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      hdr_reg.sub == TSQ_SUB_TIME |-> payload[119:114] == 6'h00 &&
      payload[113:96] == {data_reg[5][1:0], data_reg[6][15:0]};
  endproperty
  a_flags: assert property (p_flags) else $error("flags or offset");
  property p_hold;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      pend_reg && !start |=> pend_reg && !RX_READY_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("answer dropped");
endmodule : tsq_responder
`default_nettype wire

// ==== tsq_pkg.sv ====
// Purpose: shared constants and types of the timing query responder
// Assumes: 32-bit classic Wishbone, byte-wide serial stream
// Notes:   offsets are byte addresses of 32-bit words
package tsq_pkg;
  // framing bytes
  localparam logic [7:0] TSQ_START     = 8'h10;
  localparam logic [7:0] TSQ_END1      = 8'h10;
  localparam logic [7:0] TSQ_END2      = 8'h03;
  localparam logic [7:0] TSQ_PKT_ID    = 8'hA1;
  localparam logic [7:0] TSQ_SUB_TIME  = 8'h00;
  localparam logic [7:0] TSQ_SUB_FREQ  = 8'h02;
  localparam logic [7:0] TSQ_SUB_POS   = 8'h11;
  localparam logic [7:0] TSQ_SUB_ERR   = 8'hEE;
  localparam logic [7:0] TSQ_MODE_QRY  = 8'h00;
  localparam logic [7:0] TSQ_MODE_RSP  = 8'h02;
  // payload sizes in data bytes (mode and checksum excluded); TSQ_MAX_LEN bounds the length field, which counts both
  localparam int         TSQ_MAXD      = 30;
  localparam logic [5:0] TSQ_ND_TIME   = 6'd30;
  localparam logic [5:0] TSQ_ND_FREQ   = 6'd15;
  localparam logic [5:0] TSQ_ND_ERR    = 6'd0;
  localparam logic [15:0] TSQ_MAX_LEN  = 16'h0040;
  // register offsets
  localparam logic [7:0] TSQ_R_CTRL    = 8'h00;
  localparam logic [7:0] TSQ_R_STATUS  = 8'h04;
  localparam logic [7:0] TSQ_R_TOW     = 8'h08;
  localparam logic [7:0] TSQ_R_DATE    = 8'h0C;
  localparam logic [7:0] TSQ_R_HMS     = 8'h10;
  localparam logic [7:0] TSQ_R_DAY     = 8'h14;
  localparam logic [7:0] TSQ_R_UTC     = 8'h18;
  localparam logic [7:0] TSQ_R_QERR    = 8'h1C;
  localparam logic [7:0] TSQ_R_BIAS    = 8'h20;
  localparam logic [7:0] TSQ_R_BRATE   = 8'h24;
  localparam logic [7:0] TSQ_R_DACV    = 8'h28;
  localparam logic [7:0] TSQ_R_DACH    = 8'h2C;
  localparam logic [7:0] TSQ_R_HOLD    = 8'h30;
  localparam logic [7:0] TSQ_R_TEMP    = 8'h34;
  localparam int         TSQ_NWORDS    = 14;
  localparam logic [31:0] TSQ_CTRL_RST = 32'h0000_0001;
  localparam int         TSQ_CTRL_EN   = 0;
  // header handed to the framer
  typedef struct packed {
    logic [7:0] id;
    logic [7:0] sub;
    logic [7:0] mode;
  } tsq_hdr_s;
endpackage : tsq_pkg

// ==== tsq_framer.sv ====
// Purpose: sends one framed response packet, byte by byte
// Assumes: consumer takes a byte on valid and ready high together
// Notes:   no byte stuffing; payload is taken at start
`timescale 1ns/1ps
`default_nettype none
module tsq_framer
  import tsq_pkg::*;
#(
  parameter int MAXD = TSQ_MAXD
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              start_in,
  input  wire tsq_hdr_s          hdr_in,
  input  wire logic [5:0]        ndata_in,
  input  wire logic [8*MAXD-1:0] payload_in,
  output logic      [7:0]        tx_data_out,
  output logic                   tx_valid_out,
  input  wire logic              tx_ready_in,
  output logic                   busy_out
);
  tsq_hdr_s          hdr_reg;
  logic [5:0]        nd_reg;
  logic [8*MAXD-1:0] pl_reg;
  logic [5:0]        idx_reg;
  logic [7:0]        cks_reg;
  logic [7:0]        cks_next;
  logic [15:0]       len_w;
  logic              fire;

  // length counts mode, data and checksum
  assign len_w = {10'h000, nd_reg} + 16'h0002;
  assign fire  = tx_valid_out && tx_ready_in;

  // running xor from identifier to last data byte
  assign cks_next = (idx_reg >= 6'd1 && idx_reg <= nd_reg + 6'd5) ?
                    (cks_reg ^ tx_data_out) : cks_reg;

  // byte at a given position of the frame
  function automatic logic [7:0] byte_of(input logic [5:0] i,
                                         input logic [7:0] c);
    logic [8*MAXD-1:0] sh;
    sh = pl_reg << (8 * (i - 6'd6));
    if (i == 6'd0)               return TSQ_START;
    else if (i == 6'd1)          return hdr_reg.id;
    else if (i == 6'd2)          return hdr_reg.sub;
    else if (i == 6'd3)          return len_w[15:8];
    else if (i == 6'd4)          return len_w[7:0];
    else if (i == 6'd5)          return hdr_reg.mode;
    else if (i <= nd_reg + 6'd5) return sh[8*MAXD-1 -: 8];
    else if (i == nd_reg + 6'd6) return c;
    else if (i == nd_reg + 6'd7) return TSQ_END1;
    else                         return TSQ_END2;
  endfunction : byte_of

  // latch the packet at start
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hdr_reg <= '0;
      nd_reg  <= 6'd0;
      pl_reg  <= '0;
    end else if (start_in && !busy_out) begin
      hdr_reg <= hdr_in;
      nd_reg  <= ndata_in;
      pl_reg  <= payload_in;
    end
  end

  // byte sequencer; start byte is presented first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      idx_reg      <= 6'd0;
      cks_reg      <= 8'h00;
      tx_data_out  <= 8'h00;
      tx_valid_out <= 1'b0;
      busy_out     <= 1'b0;
    end else if (start_in && !busy_out) begin
      idx_reg      <= 6'd0;
      cks_reg      <= 8'h00;
      tx_data_out  <= TSQ_START;
      tx_valid_out <= 1'b1;
      busy_out     <= 1'b1;
    end else if (fire) begin
      if (idx_reg == nd_reg + 6'd8) begin
        tx_valid_out <= 1'b0;
        busy_out     <= 1'b0;
      end else begin
        idx_reg     <= idx_reg + 6'd1;
        cks_reg     <= cks_next;
        tx_data_out <= byte_of(idx_reg + 6'd1, cks_next);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_sof;
    @(posedge clk_in) disable iff (!rst_n_in)
      start_in && !busy_out |=> tx_valid_out && tx_data_out == TSQ_START;
  endproperty
  a_sof: assert property (p_sof) else $error("frame not opened");
  sequence s_cks_sent;
    fire && idx_reg == nd_reg + 6'd6;
  endsequence
  property p_tail;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_cks_sent |=> tx_valid_out && tx_data_out == TSQ_END1;
  endproperty
  a_tail: assert property (p_tail) else $error("bad end bytes");
  // the first end byte is held by valid until taken, then the second follows
  sequence s_end1_sent;
    fire && idx_reg == nd_reg + 6'd7;
  endsequence
  property p_end2;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_end1_sent |=> tx_valid_out && tx_data_out == TSQ_END2;
  endproperty
  a_end2: assert property (p_end2) else $error("bad last byte");
  property p_len;
    @(posedge clk_in) disable iff (!rst_n_in)
      fire && idx_reg == 6'd2 |=> tx_data_out == 8'h00;
  endproperty
  a_len: assert property (p_len) else $error("length high byte");
  property p_cks;
    @(posedge clk_in) disable iff (!rst_n_in)
      fire && idx_reg == nd_reg + 6'd5 |=> tx_data_out == $past(cks_next);
  endproperty
  a_cks: assert property (p_cks) else $error("bad checksum");
endmodule : tsq_framer
`default_nettype wire

// ==== tsq_host_model.sv ====
// Purpose: host side model that frames queries and collects answers
// Assumes: same clock as the responder, byte handshakes on both streams
// Notes:   an idle query line shows the inverse of its last byte
`timescale 1ns/1ps
`default_nettype none
module tsq_host_model
  import tsq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  logic [7:0] got[$];   // answer bytes in arrival order
  logic       stall_reg; // slow consumer, ready every other cycle

  // quiet lines at time zero
  initial begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
    stall_reg    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // frame a packet; checksum runs over id through the last data byte
  task automatic build(input logic [7:0] sub, input logic [7:0] mode,
                       input logic [7:0] d[$], ref logic [7:0] f[$]);
    logic [15:0] len;
    logic [7:0]  cks;
    len = 16'(d.size() + 2);
    f = {TSQ_START, TSQ_PKT_ID, sub, len[15:8], len[7:0], mode};
    foreach (d[i]) f.push_back(d[i]);
    cks = 8'h00;
    for (int i = 1; i < f.size(); i++) cks ^= f[i];
    f.push_back(cks);
    f.push_back(TSQ_END1);
    f.push_back(TSQ_END2);
  endtask : build

  // each byte is held until the edge that samples ready high
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      rx_data_out  <= f[i];
      rx_valid_out <= 1'b1;
      do @(posedge clk_in); while (rx_ready_in !== 1'b1);
    end
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~f[f.size()-1];
    // let an edge pass so a following frame never reassigns in this step
    @(posedge clk_in);
  endtask : send

  // take answer bytes; stalling shakes out a framer that skips a hold
  always @(posedge clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out) got.push_back(tx_data_in);
    tx_ready_out <= rst_n_in && (!stall_reg || !tx_ready_out);
  end
endmodule : tsq_host_model
`default_nettype wire

// ==== test_timing_status_query_responder.sv ====
// Purpose: self-checking bench for the timing query responder
// Assumes: host model drives queries, registers set over Wishbone
// Notes:   expected frames are built from register values written here
`timescale 1ns/1ps
`default_nettype none
module test_timing_status_query_responder
  import tsq_pkg::*;
;
  logic        clk, rst_n, cyc, stb, we, ack, rx_valid, rx_ready;
  logic        tx_valid, tx_ready;
  logic [7:0]  adr, rx_data, tx_data;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          errors, tests_run;
  logic [7:0]  q[$], et[$], ef[$], e[$], d[$], nod[$];
  logic [31:0] tv[12] = '{32'h0005_2998, 32'h0850_07E4, 32'h153A_300A,
    32'h1509_0303, 32'h0000_FFF2, 32'h3FB3_9E72, 32'h4042_37EB,
    32'h4279_8711, 32'h4049_0FDB, 32'h8123_0002, 32'h0000_0E10,
    32'h41C8_0000};

  tsq_responder u_dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready),
    .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready));
  tsq_host_model u_host (.clk_in(clk), .rst_n_in(rst_n),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));

  // 10 MHz clock
  always #50 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t word %h expected %h", $time, g, x);
    end
  endtask : chk32

  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t byte %h expected %h", $time, g, x);
    end
  endtask : chk8

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb_cycle(input logic [7:0] a, input logic w,
                          input logic [31:0] dv, input logic [3:0] s,
                          output logic [31:0] r);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= dv;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    chk32(32'(ack), 32'h0000_0001);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb_cycle

  task automatic wb_write(input logic [7:0] a, input logic [31:0] dv,
                          input logic [3:0] s);
    logic [31:0] r;
    wb_cycle(a, 1'b1, dv, s, r);
  endtask : wb_write

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] x);
    logic [31:0] r;
    wb_cycle(a, 1'b0, 32'h0000_0000, 4'hF, r);
    chk32(r & m, x);
  endtask : chk_reg

  // split a wide value into n bytes, most significant first
  task automatic split(input logic [239:0] v, input int n,
                       ref logic [7:0] b[$]);
    b.delete();
    for (int i = 0; i < n; i++) b.push_back(v[8*(n-1-i) +: 8]);
  endtask : split

  // wait for the whole answer, then make sure nothing extra follows
  task automatic chk_frame(input logic [7:0] x[$]);
    int n;
    n = 0;
    while (u_host.got.size() < x.size() && n < 800) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk32(32'(u_host.got.size()), 32'(x.size()));
    foreach (x[i]) if (i < u_host.got.size()) chk8(u_host.got[i], x[i]);
    u_host.got.delete();
  endtask : chk_frame

  //////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    close_out();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values and an unmapped place
    chk_reg(TSQ_R_CTRL, 32'hFFFF_FFFF, TSQ_CTRL_RST);
    chk_reg(TSQ_R_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    wb_write(8'h3C, 32'hFFFF_FFFF, 4'hF);
    chk_reg(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 12; i++) wb_write(8'h08 + 8'(4*i), tv[i], 4'hF);
    // back to back timing and frequency queries, slow consumer
    split(240'h0005_2998_0850_153A_300A_1507_E409_0303_FFF2_3FB3_9E72_4042_37EB_4279_8711,
          30, d);
    u_host.build(TSQ_SUB_TIME, TSQ_MODE_RSP, d, et);
    split(240'h0000_0000_0000_0000_4049_0FDB_8123_0200_000E_1041_C800_00,
          15, d);
    u_host.build(TSQ_SUB_FREQ, TSQ_MODE_RSP, d, ef);
    u_host.stall_reg = 1'b1;
    u_host.build(TSQ_SUB_TIME, TSQ_MODE_QRY, nod, q);
    u_host.send(q);
    u_host.build(TSQ_SUB_FREQ, TSQ_MODE_QRY, nod, q);
    u_host.send(q);
    e = {et, ef};
    chk_frame(e);
    u_host.stall_reg = 1'b0;
    // corrupt checksum gets an error frame, then the host resends
    u_host.build(TSQ_SUB_TIME, TSQ_MODE_QRY, nod, q);
    q[6] = q[6] ^ 8'h01;
    u_host.send(q);
    u_host.build(TSQ_SUB_ERR, TSQ_MODE_RSP, nod, e);
    chk_frame(e);
    q[6] = q[6] ^ 8'h01;
    u_host.send(q);
    chk_frame(et);
    chk_reg(TSQ_R_STATUS, 32'h0000_FF00, 32'h0000_0100);
    // position masks are latched and never answered
    for (int b = 0; b < 4; b++) begin
      d = {8'(1 << b)};
      u_host.build(TSQ_SUB_POS, TSQ_MODE_QRY, d, q);
      u_host.send(q);
      chk_frame(nod);
      chk_reg(TSQ_R_STATUS, 32'h000F_0000, 32'(1 << (16 + b)));
    end
    // foreign identifier and a non-query mode are dropped
    u_host.build(TSQ_SUB_TIME, TSQ_MODE_QRY, nod, q);
    q[1] = 8'hA2;
    u_host.send(q);
    u_host.build(TSQ_SUB_TIME, 8'h01, nod, q);
    u_host.send(q);
    chk_frame(nod);
    // parsing switched off: bytes are swallowed and nothing is answered
    wb_write(TSQ_R_CTRL, 32'h0000_0000, 4'hF);
    u_host.build(TSQ_SUB_TIME, TSQ_MODE_QRY, nod, q);
    u_host.send(q);
    chk_frame(nod);
    wb_write(TSQ_R_CTRL, TSQ_CTRL_RST, 4'hF);
    // byte enables touch only the selected lane
    wb_write(TSQ_R_TOW, 32'hFFFF_FFFF, 4'b0001);
    chk_reg(TSQ_R_TOW, 32'hFFFF_FFFF, 32'h0005_29FF);
    close_out();
  end
endmodule : test_timing_status_query_responder
`default_nettype wire
